// [design/hwmon_defines.svh]
`ifndef HWMON_DEFINES_SVH
`define HWMON_DEFINES_SVH
// Register indices within bank zero
`define IDX_EVT_STATUS 7'h45
`define IDX_EVT_MASK 7'h46
`define IDX_SLAVE_ADDR 7'h48
`define IDX_ALERT_CTRL 7'h4c
`define IDX_FAN_DIR_A 7'h4d
`define IDX_BANK_SEL 7'h4e
`define IDX_MAKER_ID 7'h4f
`define IDX_FAN_DIR_B 7'h50
`define IDX_PART_ID 7'h58
`define IDX_SENSOR_TYPE 7'h5d
`define IDX_CURRENT_MODE 7'h5e
`define IDX_SMI_ENABLE 7'h40
// Reset values
`define RST_EVT_MASK 8'h1e
`define RST_SLAVE_ADDR 7'h2d
`define RST_ALERT_CTRL 8'h08
`define RST_FAN_DIR_A 8'h55
`define RST_BANK_SEL 8'h80
`define RST_FAN_DIR_B 2'h1
`define RST_SENSOR_TYPE 7'h04
`define RST_CURRENT_MODE 6'h02
// Field positions
`define BIT_CLR_INTR0 7
`define BIT_CLR_INTR1 6
`define BIT_IRQ_STYLE 6
`define BIT_SINGLE_IRQ 5
`define BIT_ALERT_DIS 3
`define BIT_ALERT_POL 2
`define BIT_ID_HIGH 7
`define BIT_SMI_EN 1
// Status bit positions
`define ST_AUX_FAN 5
`define ST_CPU_FAN 4
`define ST_SYS_FAN 3
`define ST_SHUT_TWO 1
`define ST_SHUT_ONE 0
// Full speed hold time
`define FULL_SPEED_SEC 180
`define FULL_SPEED_CYCLES (35'(`FULL_SPEED_SEC) * 35'd100_000_000)
`endif

// [design/hwmon_pkg.sv]
package hwmon_pkg;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;
   typedef struct packed {
      logic [4:0] level;
      logic [4:0] oe;
   } fan_pins_s;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b11
   } hold_state_e;
endpackage

// [design/full_speed_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module full_speed_timer #(
   parameter logic [34:0] HOLD_CYCLES = 35'd18_000_000_000
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   // Fan state
   input wire logic full_i,
   output logic event_o
);
   hwmon_pkg::hold_state_e state;
   hwmon_pkg::hold_state_e next_state;
   logic [34:0] count;
   wire hit = (count >= HOLD_CYCLES - 35'd1);
   always_comb begin
      next_state = state;
      case (state)
         hwmon_pkg::ST_IDLE: if (full_i) next_state = hwmon_pkg::ST_RUN;
         hwmon_pkg::ST_RUN: begin
            if (!full_i) next_state = hwmon_pkg::ST_IDLE;
            else if (hit) next_state = hwmon_pkg::ST_DONE;
         end
         hwmon_pkg::ST_DONE: if (!full_i) next_state = hwmon_pkg::ST_IDLE;
         default: next_state = hwmon_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= hwmon_pkg::ST_IDLE;
         count <= 35'd0;
         event_o <= 1'b0;
      end else if (en_i) begin
         state <= next_state;
         count <= (state == hwmon_pkg::ST_RUN) ? count + 35'd1 : 35'd0;
         event_o <= (state == hwmon_pkg::ST_RUN) && full_i && hit;
      end
   end
endmodule // full_speed_timer
`default_nettype wire

// [design/sticky_flag.sv]
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   // Set and clear
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (en_i) begin
         flag_o <= set_i | (flag_o & ~clr_i);
      end
   end
endmodule // sticky_flag
`default_nettype wire

// [design/hwmon_regs.sv]
// Operation
// - Fan flags 5,4,3 set after three minutes full speed; register clears on read.
// - Status bits 1,0 set on shut-down limit exceed of sources two, one.
// - Mask bits 4/3 at one block status bits 1/0 from interrupt; fan bits 5-3 never masked; reset pattern 00011110.
// - Writing one to mask bits 7/6 clears intrusion zero/one; self clearing.
// - Slave address register holds seven bits, reset 0101101; bit 7 reads zero.
// - Control bit 6 picks comparator or two-times mode for sources two-six.
// - Control bit 5 picks one-time mode for source one, else two-times.
// - Control bit 3 one disables source two overheat alert on its pin.
// - Control bit 2 sets alert polarity; one high, zero low default.
// - Fan input-select bit one makes pin tach input; zero makes output.
// - Output fan pin driven high or low by its level bit, reset zero.
// - Second fan register: select bit 0 reset one, level bit 1 reset zero.
// - Bank select bits 3-0 choose bank by binary number; 6-4 reserved.
// - Bank register bit 7 picks high or low identity byte at 4Fh.
// - Read-only 16-bit maker identity returned one byte per byte-select bit.
// - Read-only part code at index 58h of bank zero.
// - Sensor bits 6-1 pick diode or thermistor; only bit 2 resets one.
// - Bit 0 enables battery monitor; first reading after one monitor cycle.
// - Current-mode bits 6-1 enable current sensing on diode inputs.
// - Management interrupt produced only while global enable is one, reset one.
`timescale 1ns/10ps
`default_nettype none
`include "hwmon_defines.svh"
module hwmon_regs #(
   parameter logic [34:0] HOLD_CYCLES = 35'(`FULL_SPEED_CYCLES),
   parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'h42, // Arbitrary value
   parameter logic [31:0] MONITOR_CYCLE = 32'd1000
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register port
   input wire logic [6:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Events from monitor
   input wire logic [2:0] fan_full_i,
   input wire logic shutdown_temp_one_flag_i,
   input wire logic shutdown_temp_two_flag_i,
   input wire logic temp_source_two_over_i,
   // Intrusion clears
   output logic intrusion_zero_clr_o,
   output logic intrusion_one_clr_o,
   // Interrupt and alert
   output logic mgmt_interrupt_out_n_o,
   output logic overheat_alert_out_o,
   // Fan pins
   output logic [4:0] fan_level_o,
   output logic [4:0] fan_oe_o,
   // Configuration out
   output logic [6:0] slave_addr_o,
   output logic sources_two_to_six_irq_style_o,
   output logic source_one_single_irq_o,
   output logic [3:0] bank_number_o,
   output logic [5:0] sensor_kind_o,
   output logic [5:0] current_mode_o,
   output logic battery_monitor_enable_o,
   output logic battery_reading_valid_o
);
   hwmon_pkg::bus_req_s req;
   hwmon_pkg::fan_pins_s pins;
   logic [7:0] mask;
   logic [6:0] slave_addr;
   logic [7:0] alert_ctrl;
   logic [7:0] fan_dir_a;
   logic [1:0] fan_dir_b;
   logic [7:0] bank_sel;
   logic [6:0] sensor_type;
   logic [5:0] current_mode;
   logic smi_enable;
   logic [31:0] vbat_count;
   logic vbat_busy;
   logic [2:0] fan_evt;
   logic [7:0] status;
   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   wire bank0 = (bank_sel[3:0] == 4'h0);
   wire idx_bank = (req.addr == `IDX_BANK_SEL);
   wire sel_ok = bank0 || idx_bank;
   wire wr_hit = req.wr && sel_ok;
   wire rd_hit = req.rd && sel_ok;
   wire wr_mask = wr_hit && (req.addr == `IDX_EVT_MASK);
   wire wr_addr = wr_hit && (req.addr == `IDX_SLAVE_ADDR);
   wire wr_alert = wr_hit && (req.addr == `IDX_ALERT_CTRL);
   wire wr_fan_a = wr_hit && (req.addr == `IDX_FAN_DIR_A);
   wire wr_bank = req.wr && idx_bank;
   wire wr_fan_b = wr_hit && (req.addr == `IDX_FAN_DIR_B);
   wire wr_sensor = wr_hit && (req.addr == `IDX_SENSOR_TYPE);
   wire wr_cur = wr_hit && (req.addr == `IDX_CURRENT_MODE);
   wire wr_smi = wr_hit && (req.addr == `IDX_SMI_ENABLE);
   wire rd_status = rd_hit && (req.addr == `IDX_EVT_STATUS);
   wire [7:0] set_vec = {2'b00, fan_evt, 1'b0,
      shutdown_temp_two_flag_i, shutdown_temp_one_flag_i};
   wire [7:0] mask_bits = {3'b000, mask[4:0]};
   wire [7:0] fan_part = status & 8'h38;
   wire [7:0] shut_part = status & {6'b00_0000, ~mask[4], ~mask[3]};
   wire [7:0] unmasked = fan_part | shut_part;
   wire irq_any = |unmasked;
   wire alert_raw = temp_source_two_over_i & ~alert_ctrl[`BIT_ALERT_DIS];
   wire alert_pin = alert_ctrl[`BIT_ALERT_POL] ? alert_raw : ~alert_raw;
   wire [7:0] id_byte = bank_sel[`BIT_ID_HIGH] ? MAKER_ID[15:8]
      : MAKER_ID[7:0];
   wire vbat_rise = wr_sensor && wdata_i[0] && !sensor_type[0];
   always_comb begin
      pins.oe = ~{fan_dir_b[0], fan_dir_a[6], fan_dir_a[4],
         fan_dir_a[2], fan_dir_a[0]};
      pins.level = {fan_dir_b[1], fan_dir_a[7], fan_dir_a[5],
         fan_dir_a[3], fan_dir_a[1]} & pins.oe;
   end
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (rd_hit) begin
         case (req.addr)
            `IDX_EVT_STATUS: next_rdata = status;
            `IDX_EVT_MASK: next_rdata = mask_bits;
            `IDX_SLAVE_ADDR: next_rdata = {1'b0, slave_addr};
            `IDX_ALERT_CTRL: next_rdata = alert_ctrl & 8'h6c;
            `IDX_FAN_DIR_A: next_rdata = fan_dir_a;
            `IDX_BANK_SEL: next_rdata = bank_sel & 8'h8f;
            `IDX_MAKER_ID: next_rdata = id_byte;
            `IDX_FAN_DIR_B: next_rdata = {6'b00_0000, fan_dir_b};
            `IDX_PART_ID: next_rdata = PART_ID;
            `IDX_SENSOR_TYPE: next_rdata = {1'b0, sensor_type};
            `IDX_CURRENT_MODE: next_rdata = {1'b0, current_mode, 1'b0};
            `IDX_SMI_ENABLE: next_rdata = {6'b00_0000, smi_enable, 1'b0};
            default: next_rdata = 8'h00;
         endcase
      end
   end
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_fan
         full_speed_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_timer (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .en_i(ce_i),
            .full_i(fan_full_i[g]),
            .event_o(fan_evt[g])
         );
      end
      for (g = 0; g < 8; g++) begin : g_status
         sticky_flag u_flag (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .en_i(ce_i),
            .set_i(set_vec[g]),
            .clr_i(rd_status),
            .flag_o(status[g])
         );
      end
   endgenerate
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask <= `RST_EVT_MASK;
         slave_addr <= `RST_SLAVE_ADDR;
         alert_ctrl <= `RST_ALERT_CTRL;
         fan_dir_a <= `RST_FAN_DIR_A;
         fan_dir_b <= `RST_FAN_DIR_B;
         bank_sel <= `RST_BANK_SEL;
         sensor_type <= `RST_SENSOR_TYPE;
         current_mode <= `RST_CURRENT_MODE;
         smi_enable <= 1'b1;
      end else if (ce_i) begin
         if (wr_mask) mask <= {3'b000, wdata_i[4:0]};
         if (wr_addr) slave_addr <= wdata_i[6:0];
         if (wr_alert) alert_ctrl <= wdata_i & 8'h6c;
         if (wr_fan_a) fan_dir_a <= wdata_i;
         if (wr_fan_b) fan_dir_b <= wdata_i[1:0];
         if (wr_bank) bank_sel <= wdata_i & 8'h8f;
         if (wr_sensor) sensor_type <= wdata_i[6:0];
         if (wr_cur) current_mode <= wdata_i[6:1];
         if (wr_smi) smi_enable <= wdata_i[`BIT_SMI_EN];
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vbat_count <= 32'd0;
         vbat_busy <= 1'b0;
         battery_reading_valid_o <= 1'b0;
      end else if (ce_i) begin
         if (vbat_rise) begin
            vbat_busy <= 1'b1;
            vbat_count <= 32'd0;
            battery_reading_valid_o <= 1'b0;
         end else if (!sensor_type[0]) begin
            vbat_busy <= 1'b0;
            battery_reading_valid_o <= 1'b0;
         end else if (vbat_busy) begin
            vbat_count <= vbat_count + 32'd1;
            if (vbat_count >= MONITOR_CYCLE - 32'd1) begin
               vbat_busy <= 1'b0;
               battery_reading_valid_o <= 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         intrusion_zero_clr_o <= 1'b0;
         intrusion_one_clr_o <= 1'b0;
         mgmt_interrupt_out_n_o <= 1'b1;
         overheat_alert_out_o <= 1'b1;
         fan_level_o <= 5'h00;
         fan_oe_o <= 5'h00;
      end else if (ce_i) begin
         rdata_o <= next_rdata;
         intrusion_zero_clr_o <= wr_mask && wdata_i[`BIT_CLR_INTR0];
         intrusion_one_clr_o <= wr_mask && wdata_i[`BIT_CLR_INTR1];
         mgmt_interrupt_out_n_o <= ~(irq_any & smi_enable);
         overheat_alert_out_o <= alert_pin;
         fan_level_o <= pins.level;
         fan_oe_o <= pins.oe;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slave_addr_o <= `RST_SLAVE_ADDR;
         sources_two_to_six_irq_style_o <= 1'b0;
         source_one_single_irq_o <= 1'b0;
         bank_number_o <= 4'h0;
         sensor_kind_o <= 6'h02;
         current_mode_o <= `RST_CURRENT_MODE;
         battery_monitor_enable_o <= 1'b0;
      end else if (ce_i) begin
         slave_addr_o <= slave_addr;
         sources_two_to_six_irq_style_o <= alert_ctrl[`BIT_IRQ_STYLE];
         source_one_single_irq_o <= alert_ctrl[`BIT_SINGLE_IRQ];
         bank_number_o <= bank_sel[3:0];
         sensor_kind_o <= sensor_type[6:1];
         current_mode_o <= current_mode & sensor_type[6:1];
         battery_monitor_enable_o <= sensor_type[0];
      end
   end
endmodule // hwmon_regs
`default_nettype wire

// [test/hwmon_regs_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module hwmon_regs_checker #(
   parameter logic [7:0] PART_ID = 8'h42
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [6:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Events
   input wire logic [2:0] fan_full_i,
   input wire logic shutdown_temp_one_flag_i,
   input wire logic shutdown_temp_two_flag_i,
   // Outputs
   input wire logic intrusion_zero_clr_o,
   input wire logic intrusion_one_clr_o,
   input wire logic mgmt_interrupt_out_n_o,
   input wire logic [4:0] fan_level_o,
   input wire logic [4:0] fan_oe_o,
   input wire logic [6:0] slave_addr_o,
   input wire logic [3:0] bank_number_o,
   input wire logic [5:0] sensor_kind_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic b0 = (bank_number_o == 4'h0);
   wire logic quiet = (fan_full_i == 3'h0) && !shutdown_temp_one_flag_i &&
      !shutdown_temp_two_flag_i;
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
   part_code_a: assert property (rd_i && addr_i == 7'h58 && b0 |=>
      rdata_o == PART_ID) else $error("part code wrong");
   clear_zero_a: assert property (wr_i && addr_i == 7'h46 &&
      wdata_i[7] && b0 |=> intrusion_zero_clr_o) else $error("no clear 0");
   clear_one_a: assert property (intrusion_one_clr_o |->
      $past(wr_i && addr_i == 7'h46 && wdata_i[6]) ##1 !intrusion_one_clr_o)
      else $error("bad clear 1 pulse");
   pin_level_a: assert property ((fan_level_o & ~fan_oe_o) == 5'h00)
      else $error("input pin driven");
   fan_dir_a: assert property (wr_i && addr_i == 7'h4d && b0 |-> ##2
      fan_oe_o[3:0] == ~$past({wdata_i[6], wdata_i[4], wdata_i[2],
      wdata_i[0]}, 2)) else $error("fan direction wrong");
   slave_addr_a: assert property (wr_i && addr_i == 7'h48 && b0 |-> ##2
      slave_addr_o == $past(wdata_i[6:0], 2)) else $error("address wrong");
   bank_sel_a: assert property (wr_i && addr_i == 7'h4e |-> ##2
      bank_number_o == $past(wdata_i[3:0], 2)) else $error("bank wrong");
   sensor_kind_a: assert property (wr_i && addr_i == 7'h5d && b0 |-> ##2
      sensor_kind_o == $past(wdata_i[6:1], 2)) else $error("kind wrong");
   irq_release_a: assert property (quiet[*2] ##0 (rd_i &&
      addr_i == 7'h45 && b0) ##1 quiet[*3] |=> mgmt_interrupt_out_n_o)
      else $error("interrupt held after status read");
endmodule // hwmon_regs_checker
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
   logic [6:0] addr_i = 0, a, sadr;
   logic [7:0] wdata_i = 0, rdata_o, d, fa = 8'h55, fb = 8'h01;
   logic [2:0] full = 0;
   logic sh1 = 0, sh2 = 0, over = 0, izc, ioc, irq_n, alert, bat_v, bat_e;
   logic sty, one, ce = 1;
   logic [4:0] lvl, oe;
   logic [3:0] bank;
   logic [5:0] kind, cur;
   int num_errors = 0, num_checks = 0, cyc = 0, i, j;
   logic [6:0] ra [12] = '{7'h45, 7'h46, 7'h48, 7'h4c, 7'h4d, 7'h4e, 7'h4f,
      7'h50, 7'h58, 7'h5d, 7'h5e, 7'h47};
   logic [7:0] rv [12] = '{8'h00, 8'h1e, 8'h2d, 8'h08, 8'h55, 8'h80, 8'h12,
      8'h01, 8'h42, 8'h04, 8'h04, 8'h00};
   logic [6:0] wa [6] = '{7'h48, 7'h4c, 7'h4d, 7'h50, 7'h5d, 7'h5e};
   logic [7:0] wm [6] = '{8'h7f, 8'h6c, 8'hff, 8'h03, 8'h7f, 8'h7e};
   logic [18:0] sv [4] = '{{8'h18, 8'h03, 3'b111}, {8'h08, 8'h03, 3'b110},
      {8'h10, 8'h03, 3'b100}, {8'h00, 8'h01, 3'b111}};
   logic [9:0] al [6] = '{{8'h00, 2'b10}, {8'h00, 2'b01}, {8'h04, 2'b11},
      {8'h04, 2'b00}, {8'h0c, 2'b10}, {8'h08, 2'b11}};
   always #5 clk_i = ~clk_i;
   hwmon_regs #(.HOLD_CYCLES(35'h14), .MONITOR_CYCLE(32'h0000_000a))
   u_hwmon_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .fan_full_i(full), .shutdown_temp_one_flag_i(sh1),
      .shutdown_temp_two_flag_i(sh2), .temp_source_two_over_i(over),
      .intrusion_zero_clr_o(izc), .intrusion_one_clr_o(ioc),
      .mgmt_interrupt_out_n_o(irq_n), .overheat_alert_out_o(alert),
      .fan_level_o(lvl), .fan_oe_o(oe), .slave_addr_o(sadr),
      .sources_two_to_six_irq_style_o(sty), .source_one_single_irq_o(one),
      .bank_number_o(bank), .sensor_kind_o(kind), .current_mode_o(cur),
      .battery_monitor_enable_o(bat_e), .battery_reading_valid_o(bat_v));
   function automatic logic [9:0] fan_exp(input logic [7:0] x, y);
      logic [4:0] o;
      o = ~{y[0], x[6], x[4], x[2], x[0]};
      return {{y[1], x[7], x[5], x[3], x[1]} & o, o};
   endfunction
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [6:0] x, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= x;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [6:0] x, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= x;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   task automatic ev(input logic [2:0] f, input logic s1, s2);
      @(posedge clk_i);
      full <= f;
      sh1 <= s1;
      sh2 <= s2;
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         finish_test;
      end
   end
   initial begin
      i = $urandom(32'hdce9);
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (ra[k]) rd(ra[k], rv[k]);
      chk({lvl, oe, irq_n}, 11'h001);
      $display("reset test done");
      for (i = 0; i < 30; i++) begin
         j = $urandom_range(5);
         a = wa[j];
         d = $urandom;
         wr(a, d);
         if (a == 7'h4d) fa = d;
         if (a == 7'h50) fb = d;
         rd(a, d & wm[j]);
         chk({lvl, oe}, fan_exp(fa, fb));
         if (a == 7'h48) chk(sadr, d[6:0]);
      end
      $display("random test done");
      wr(7'h4e, 8'h00);
      rd(7'h4f, 8'h34);
      wr(7'h4e, 8'hf3);
      rd(7'h4e, 8'h83);
      rd(7'h58, 8'h00);
      chk(bank, 4'h3);
      wr(7'h4e, 8'h80);
      rd(7'h4f, 8'h12);
      wr(7'h46, 8'hc0);
      chk({izc, ioc}, 2'b11);
      w(1);
      chk({izc, ioc}, 2'b00);
      rd(7'h46, 8'h00);
      $display("bank and clear test done");
      wr(7'h46, 8'h18);
      ev(3'b011, 1'b0, 1'b0);
      w(30);
      chk(irq_n, 1'b0);
      ev(3'b111, 1'b0, 1'b0);
      w(30);
      ev(3'b000, 1'b0, 1'b0);
      w(4);
      rd(7'h45, 8'h38);
      foreach (sv[k]) begin
         wr(7'h46, sv[k][18:11]);
         wr(7'h40, sv[k][10:3]);
         ev(3'b000, sv[k][2], sv[k][1]);
         ev(3'b000, 1'b0, 1'b0);
         w(4);
         chk(irq_n, sv[k][0]);
         rd(7'h45, {6'h00, sv[k][1], sv[k][2]});
         w(3);
         chk(irq_n, 1'b1);
      end
      $display("status test done");
      foreach (al[k]) begin
         wr(7'h4c, al[k][9:2]);
         @(posedge clk_i);
         over <= al[k][1];
         w(3);
         chk(alert, al[k][0]);
      end
      wr(7'h4c, 8'h60);
      w(2);
      chk({sty, one}, 2'b11);
      $display("alert test done");
      wr(7'h5d, 8'h00);
      wr(7'h5d, 8'h05);
      w(4);
      chk({bat_e, bat_v}, 2'b10);
      w(10);
      chk(bat_v, 1'b1);
      wr(7'h5e, 8'h7e);
      w(2);
      chk(cur, 6'h02);
      @(posedge clk_i);
      ce <= 1'b0;
      wr(7'h5e, 8'h00);
      @(posedge clk_i);
      ce <= 1'b1;
      rd(7'h5e, 8'h7e);
      w(2);
      chk(cur, 6'h02);
      $display("sensor test done");
      finish_test;
   end
endmodule // testbench
bind hwmon_regs hwmon_regs_checker #(.PART_ID(PART_ID)) u_hwmon_regs_checker (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fan_full_i(fan_full_i),
   .shutdown_temp_one_flag_i(shutdown_temp_one_flag_i),
   .shutdown_temp_two_flag_i(shutdown_temp_two_flag_i),
   .intrusion_zero_clr_o(intrusion_zero_clr_o),
   .intrusion_one_clr_o(intrusion_one_clr_o),
   .mgmt_interrupt_out_n_o(mgmt_interrupt_out_n_o),
   .fan_level_o(fan_level_o), .fan_oe_o(fan_oe_o),
   .slave_addr_o(slave_addr_o), .bank_number_o(bank_number_o),
   .sensor_kind_o(sensor_kind_o));
`default_nettype wire
